//--- verilog/frp_host.sv
// Host controller driving a byte-wide flash through its reset, protect and autoselect pins
//
// Summary of operation
// - Wait recovery time after reset before reading
// - Restart operations that a reset interrupted; the code only sets the restart status bit for software
// - Programmer raises A9 for hardware autoselect
// - Autoselect also reachable by command writes
// - Protect methods use elevated reset, bus timing
// - Protect all sectors before first unprotect
// - Alternate method needs elevated A9 and OE; the code has no alternate method
// - Read: chip and output enable low
// - Write: chip and write enable low
`timescale 1ns/10ps
`default_nettype none
`include "frp_defines.svh"

module frp_host (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`FRP_PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Flash control pins
   output logic flash_reset_n,
   output logic reset_elevated,
   output logic a9_elevated,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic [`FRP_ADDR_W-1:0] flash_addr,
   // Flash data pins
   input wire logic [`FRP_DATA_W-1:0] byte_lines_in,
   output logic [`FRP_DATA_W-1:0] byte_lines_out,
   output logic byte_lines_oe,
   // Flash status pin
   input wire logic ready_busy_n
);

   frp_pkg::frp_regs_type r;
   frp_pkg::frp_regs_type next_r;
   logic tmr_load;
   logic [`FRP_TMR_W-1:0] tmr_value;
   logic tmr_expired;

   frp_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .load(tmr_load),
      .value(tmr_value),
      .expired(tmr_expired)
   );

   always_comb begin
      logic access;
      logic go;
      logic [`FRP_SECT_MSB-`FRP_SECT_LSB:0] sect;
      frp_pkg::frp_op_type new_op;
      access = psel && penable && !r.pready;
      go = 1'b0;
      sect = r.faddr[`FRP_SECT_MSB:`FRP_SECT_LSB];
      new_op = frp_pkg::frp_op_type'(pwdata[`FRP_CTRL_OP_MSB:`FRP_CTRL_OP_LSB]);
      next_r = r;
      tmr_load = 1'b0;
      tmr_value = '0;
      next_r.pready = 1'b0;
      next_r.pslverr = 1'b0;

      // Register bus: answer one cycle into the access phase
      if (access) begin
         next_r.pready = 1'b1;
         next_r.prdata = `FRP_ZERO32;
         if (pwrite) begin
            unique case (paddr)
               `FRP_OFS_CTRL: begin
                  next_r.temp = pwdata[`FRP_CTRL_TEMP];
                  go = pwdata[`FRP_CTRL_GO];
               end
               `FRP_OFS_ADDR: next_r.addr = pwdata[`FRP_ADDR_W-1:0];
               `FRP_OFS_WDATA: next_r.wdata = pwdata[`FRP_DATA_W-1:0];
               `FRP_OFS_STATUS: begin
                  // Write one to clear; a set below still wins
                  if (pwdata[`FRP_ST_REFUSED]) begin
                     next_r.refused = 1'b0;
                  end
                  if (pwdata[`FRP_ST_RESTART]) begin
                     next_r.restart = 1'b0;
                  end
               end
               `FRP_OFS_PROTMAP: next_r.pslverr = 1'b1;
               default: next_r.pslverr = 1'b1;
            endcase
         end else begin
            unique case (paddr)
               `FRP_OFS_CTRL: begin
                  next_r.prdata[`FRP_CTRL_OP_MSB:`FRP_CTRL_OP_LSB] = r.op;
                  next_r.prdata[`FRP_CTRL_TEMP] = r.temp;
               end
               `FRP_OFS_ADDR: next_r.prdata[`FRP_ADDR_W-1:0] = r.addr;
               `FRP_OFS_WDATA: next_r.prdata[`FRP_DATA_W-1:0] = r.wdata;
               `FRP_OFS_STATUS: begin
                  next_r.prdata[`FRP_ST_BUSY] = (r.state != frp_pkg::st_idle);
                  next_r.prdata[`FRP_ST_RDY] = ready_busy_n;
                  next_r.prdata[`FRP_ST_REFUSED] = r.refused;
                  next_r.prdata[`FRP_ST_RESTART] = r.restart;
                  next_r.prdata[`FRP_ST_TEMP] = r.rst_hv;
                  next_r.prdata[`FRP_ST_DATA_MSB:`FRP_ST_DATA_LSB] = r.rdata;
               end
               `FRP_OFS_PROTMAP: next_r.prdata = r.protmap;
               default: next_r.pslverr = 1'b1;
            endcase
         end
      end

      unique case (r.state)
         frp_pkg::st_idle: begin
            // temporary unprotect level follows software while idle
            next_r.rst_hv = r.temp;
            // A9 low outside reads: no alternate method
            next_r.a9_hv = 1'b0;
            if (go) begin
               next_r.op = new_op;
               next_r.faddr = r.addr;
               unique case (new_op)
                  frp_pkg::op_read, frp_pkg::op_auto_read: begin
                     next_r.a9_hv = (new_op == frp_pkg::op_auto_read);
                     next_r.ce_n = 1'b0;
                     next_r.oe_n = 1'b0;
                     next_r.doe = 1'b0;
                     next_r.state = frp_pkg::st_read_acc;
                     tmr_load = 1'b1;
                     tmr_value = `FRP_TMR_W'(`FRP_CYC_MIN(`FRP_T_ACC_NS));
                  end
                  frp_pkg::op_write, frp_pkg::op_prot_set, frp_pkg::op_prot_clr: begin
                     if (new_op != frp_pkg::op_write) begin
                        // protect cycles: elevated reset, A1 high, A0 low
                        next_r.rst_hv = 1'b1;
                        next_r.faddr[`FRP_A1] = 1'b1;
                        next_r.faddr[`FRP_A0] = 1'b0;
                        next_r.faddr[`FRP_A6] = (new_op == frp_pkg::op_prot_clr);
                     end
                     // unprotect refused until every sector is protected
                     if (new_op == frp_pkg::op_prot_clr && r.protmap != `FRP_ALL_PROT) begin
                        next_r.refused = 1'b1;
                        next_r.rst_hv = r.temp;
                     end else begin
                        // write strobes with output enable high
                        next_r.oe_n = 1'b1;
                        next_r.ce_n = 1'b0;
                        next_r.we_n = 1'b0;
                        next_r.dout = r.wdata;
                        next_r.doe = 1'b1;
                        next_r.state = frp_pkg::st_write_pulse;
                        tmr_load = 1'b1;
                        tmr_value = `FRP_TMR_W'(`FRP_CYC_MIN(`FRP_T_WP_NS));
                     end
                  end
                  frp_pkg::op_reset: begin
                     // busy at reset means the operation was cut short
                     if (!ready_busy_n) begin
                        next_r.restart = 1'b1;
                     end
                     next_r.rst_hv = 1'b0;
                     next_r.rst_n = 1'b0;
                     next_r.ce_n = 1'b1;
                     next_r.oe_n = 1'b1;
                     next_r.we_n = 1'b1;
                     next_r.doe = 1'b0;
                     next_r.state = frp_pkg::st_rst_low;
                     tmr_load = 1'b1;
                     tmr_value = `FRP_TMR_W'(`FRP_CYC_MIN(`FRP_T_RP_NS));
                  end
                  default: begin
                     // Undefined operation codes are refused, not guessed at
                     next_r.refused = 1'b1;
                  end
               endcase
            end else if (access && pwrite && paddr == `FRP_OFS_CTRL) begin
               next_r.op = r.op;
            end
         end
         frp_pkg::st_read_acc: begin
            if (tmr_expired) begin
               next_r.rdata = byte_lines_in;
               next_r.ce_n = 1'b1;
               next_r.oe_n = 1'b1;
               next_r.a9_hv = 1'b0;
               // protection verify read updates the sector shadow
               if (r.op == frp_pkg::op_auto_read && !r.faddr[`FRP_A6] && r.faddr[`FRP_A1]
                   && !r.faddr[`FRP_A0]) begin
                  // sector index from the top address bits
                  next_r.protmap[sect] = (byte_lines_in == `FRP_PROT_YES);
               end
               next_r.state = frp_pkg::st_idle;
            end
         end
         frp_pkg::st_write_pulse: begin
            if (tmr_expired) begin
               next_r.we_n = 1'b1;
               next_r.ce_n = 1'b1;
               next_r.state = frp_pkg::st_write_hold;
               tmr_load = 1'b1;
               tmr_value = `FRP_TMR_W'(`FRP_CYC_MIN(`FRP_T_WH_NS));
            end
         end
         frp_pkg::st_write_hold: begin
            if (tmr_expired) begin
               // data released only after write enable rose and the hold time passed
               next_r.doe = 1'b0;
               if (r.op == frp_pkg::op_prot_set) begin
                  next_r.protmap[sect] = 1'b1;
               end else if (r.op == frp_pkg::op_prot_clr) begin
                  next_r.protmap = `FRP_ZERO32;
               end
               next_r.state = frp_pkg::st_idle;
            end
         end
         frp_pkg::st_rst_low: begin
            // pulse held for the least reset width
            if (tmr_expired) begin
               next_r.rst_n = 1'b1;
               next_r.state = frp_pkg::st_rst_wait;
            end
         end
         frp_pkg::st_rst_wait: begin
            // wait for the device to report its reset complete
            if (ready_busy_n) begin
               next_r.state = frp_pkg::st_recover;
               tmr_load = 1'b1;
               tmr_value = `FRP_TMR_W'(`FRP_CYC_MIN(`FRP_T_RH_NS));
            end
         end
         frp_pkg::st_recover: begin
            // no new cycle until recovery time has passed
            if (tmr_expired) begin
               next_r.state = frp_pkg::st_idle;
            end
         end
         default: next_r.state = frp_pkg::st_idle;
      endcase

      // A start while busy is not queued; software must retry
      if (go && r.state != frp_pkg::st_idle) begin
         next_r.refused = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.state <= frp_pkg::st_idle;
         r.op <= frp_pkg::op_read;
         r.rst_n <= 1'b1;
         r.ce_n <= 1'b1;
         r.oe_n <= 1'b1;
         r.we_n <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign flash_reset_n = r.rst_n;
   assign reset_elevated = r.rst_hv;
   assign a9_elevated = r.a9_hv;
   assign flash_ce_n = r.ce_n;
   assign flash_oe_n = r.oe_n;
   assign flash_we_n = r.we_n;
   assign flash_addr = r.faddr;
   assign byte_lines_out = r.dout;
   assign byte_lines_oe = r.doe;

endmodule
`default_nettype wire

//--- include/frp_defines.svh
// Constants of the flash reset, protect and autoselect host controller
`ifndef FRP_DEFINES_SVH
`define FRP_DEFINES_SVH

// Flash pin widths and sector count
`define FRP_ADDR_W 21
`define FRP_DATA_W 8
`define FRP_SECT_N 32

// Register bus
`define FRP_PADDR_W 8
`define FRP_OFS_CTRL 8'h00
`define FRP_OFS_ADDR 8'h04
`define FRP_OFS_WDATA 8'h08
`define FRP_OFS_STATUS 8'h0c
`define FRP_OFS_PROTMAP 8'h10

// Control register fields
`define FRP_CTRL_GO 0
`define FRP_CTRL_OP_LSB 1
`define FRP_CTRL_OP_MSB 3
`define FRP_CTRL_TEMP 4

// Status register fields
`define FRP_ST_BUSY 0
`define FRP_ST_RDY 1
`define FRP_ST_REFUSED 2
`define FRP_ST_RESTART 3
`define FRP_ST_TEMP 4
`define FRP_ST_DATA_LSB 8
`define FRP_ST_DATA_MSB 15

// Address bits with a meaning in autoselect and protection cycles
`define FRP_A0 0
`define FRP_A1 1
`define FRP_A6 6
`define FRP_SECT_LSB 16
`define FRP_SECT_MSB 20

// Values
`define FRP_PROT_YES 8'h01
`define FRP_ALL_PROT 32'hffffffff
`define FRP_ZERO32 32'h00000000

// Timing, in ns, and the clock period
`define FRP_CLK_NS 50
`define FRP_T_RP_NS 500
`define FRP_T_RH_NS 50
`define FRP_T_ACC_NS 120
`define FRP_T_WP_NS 50
`define FRP_T_WH_NS 50
`define FRP_CYC_MIN(ns) (((ns) + `FRP_CLK_NS - 1) / `FRP_CLK_NS)
`define FRP_TMR_W 8

`endif

//--- include/frp_pkg.sv
// Types of the flash reset, protect and autoselect host controller
`include "frp_defines.svh"

package frp_pkg;

   typedef enum logic [2:0] {
      op_read,
      op_write,
      op_reset,
      op_auto_read,
      op_prot_set,
      op_prot_clr
   } frp_op_type;

   typedef enum logic [2:0] {
      st_idle,
      st_read_acc,
      st_write_pulse,
      st_write_hold,
      st_rst_low,
      st_rst_wait,
      st_recover
   } frp_state_type;

   typedef struct packed {
      frp_state_type state;
      frp_op_type op;
      logic temp;
      logic [`FRP_ADDR_W-1:0] addr;
      logic [`FRP_DATA_W-1:0] wdata;
      logic [`FRP_DATA_W-1:0] rdata;
      logic refused;
      logic restart;
      logic [`FRP_SECT_N-1:0] protmap;
      logic rst_n;
      logic rst_hv;
      logic a9_hv;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [`FRP_ADDR_W-1:0] faddr;
      logic [`FRP_DATA_W-1:0] dout;
      logic doe;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } frp_regs_type;

   typedef struct packed {
      logic [`FRP_TMR_W-1:0] count;
   } frp_tmr_type;

endpackage

//--- verilog/frp_timer.sv
// Cycle timer: loads a count and reports when it has run down
`timescale 1ns/10ps
`default_nettype none
`include "frp_defines.svh"

module frp_timer (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Load and status
   input wire logic load,
   input wire logic [`FRP_TMR_W-1:0] value,
   output logic expired
);

   frp_pkg::frp_tmr_type r;
   frp_pkg::frp_tmr_type next_r;

   always_comb begin
      next_r = r;
      if (load) begin
         next_r.count = value;
      end else if (r.count != '0) begin
         next_r.count = r.count - `FRP_TMR_W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign expired = (r.count == '0);

endmodule
`default_nettype wire

//--- tb/frp_host_props.sv
// Concurrent checks on the flash host controller ports
`timescale 1ns/10ps
`default_nettype none
`include "frp_defines.svh"

module frp_host_props (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Flash pins
   input wire logic flash_reset_n,
   input wire logic reset_elevated,
   input wire logic a9_elevated,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic byte_lines_oe
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Length of the current flash reset pulse, saturating so it never wraps
   logic [3:0] low_cnt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt <= 4'h0;
      end else if (flash_reset_n) begin
         low_cnt <= 4'h0;
      end else if (low_cnt != 4'hf) begin
         low_cnt <= low_cnt + 4'h1;
      end
   end

   a_access_answer: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   a_pready_pulse: assert property (pready |-> psel && penable ##1 !pready)
      else $error("pready not a single access pulse");
   a_slverr_pready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_read_pins: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n)
      else $error("read with bad strobes");
   a_write_pins: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && byte_lines_oe)
      else $error("write with bad strobes");
   a_bus_free: assert property (!flash_oe_n |-> !byte_lines_oe)
      else $error("controller drives bus during read");
   a_reset_quiet: assert property (!flash_reset_n |-> flash_ce_n && flash_oe_n && flash_we_n)
      else $error("bus cycle during flash reset");
   a_reset_pulse: assert property ($rose(flash_reset_n) |-> int'(low_cnt) >= `FRP_CYC_MIN(`FRP_T_RP_NS))
      else $error("flash reset pulse too short");
   a_recover_wait: assert property ($rose(flash_reset_n) |-> flash_oe_n [*2])
      else $error("read too soon after flash reset");
   a_elev_alone: assert property (reset_elevated |-> !a9_elevated && flash_reset_n)
      else $error("elevated pins mixed");
   a_autosel_read: assert property ($rose(a9_elevated) |-> !flash_oe_n && !flash_ce_n)
      else $error("A9 raised outside a read");
endmodule

bind frp_host frp_host_props frp_host_props_inst (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pready(pready),
   .pslverr(pslverr),
   .flash_reset_n(flash_reset_n),
   .reset_elevated(reset_elevated),
   .a9_elevated(a9_elevated),
   .flash_ce_n(flash_ce_n),
   .flash_oe_n(flash_oe_n),
   .flash_we_n(flash_we_n),
   .byte_lines_oe(byte_lines_oe)
);
`default_nettype wire

//--- tb/frp_flash_model.sv
// Behavioural model of the byte-wide flash: reset, autoselect, protection
`timescale 1ns/10ps
`default_nettype none
`include "frp_defines.svh"

module frp_flash_model #(
   // Identification codes: arbitrary values
   parameter logic [7:0] MAKER_ID = 8'h3c,
   parameter logic [7:0] PART_ID = 8'h7e,
   parameter int BUSY_CYC = 40,
   parameter int T_EMB = 60
) (
   // Timing reference
   input wire logic pclk,
   // Control pins
   input wire logic reset_n,
   input wire logic reset_hv,
   input wire logic a9_hv,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [`FRP_ADDR_W-1:0] addr,
   // Data and status
   output logic [`FRP_DATA_W-1:0] dout,
   output logic dout_oe,
   output logic ready_busy_n
);
   // one flag per sector, all clear
   logic [31:0] prot = 32'h00000000;
   logic [7:0] cnt = 8'h00;
   logic pend = 1'b0;
   logic rst_q = 1'b1;
   logic whv;
   logic [`FRP_ADDR_W-1:0] wa;

   assign dout_oe = reset_n && !ce_n && !oe_n && we_n;
   assign dout = !a9_hv ? (addr[7:0] ^ 8'h5a) :
      addr[1] ? (prot[addr[20:16]] ? 8'h01 : 8'h00) : (addr[0] ? PART_ID : MAKER_ID);
   assign ready_busy_n = (cnt == 8'h00);

   always @(posedge pclk) begin
      rst_q <= reset_n;
      if (!reset_n) begin
         pend <= 1'b0;
         // busy stretched only if it was busy
         if (rst_q && cnt != 8'h00) begin
            cnt <= 8'(T_EMB);
         end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
         end
      end else begin
         if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
         end
         if (!ce_n && !we_n) begin
            pend <= 1'b1;
            wa <= addr;
            whv <= reset_hv;
         end else if (pend) begin
            pend <= 1'b0;
            if (whv && wa[1] && !wa[0]) begin
               if (wa[6]) begin
                  prot <= 32'h00000000;
               end else begin
                  prot[wa[20:16]] <= 1'b1;
               end
            end else if (cnt == 8'h00 && !(prot[wa[20:16]] && !whv)) begin
               cnt <= 8'(BUSY_CYC);
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/frp_host_test.sv
// Self-checking bench for the flash host controller
`timescale 1ns/10ps
`default_nettype none
`include "frp_defines.svh"

module frp_host_test;
   localparam logic [7:0] CT = `FRP_OFS_CTRL;
   localparam logic [7:0] AD = `FRP_OFS_ADDR;
   localparam logic [7:0] ST = `FRP_OFS_STATUS;
   localparam logic [7:0] PM = `FRP_OFS_PROTMAP;
   // Identification codes, arbitrary values
   localparam logic [7:0] MAKER = 8'h3c;
   localparam logic [7:0] PART = 8'h7e;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, temp;
   logic f_rst_n, f_hv, f_a9, f_ce_n, f_oe_n, f_we_n, h_oe, m_oe, rdy_n;
   logic [7:0] paddr, h_out, m_out, bus_in, bus_last, wr_byte;
   logic [20:0] f_addr;
   logic [31:0] pwdata, prdata, rd, st;
   int mismatches, n_tests, cycles, t0;

   // Released bus shows the inverse of its last value, never a stale match
   assign bus_in = m_oe ? m_out : (h_oe ? h_out : ~bus_last);

   frp_host frp_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flash_reset_n(f_rst_n), .reset_elevated(f_hv), .a9_elevated(f_a9),
      .flash_ce_n(f_ce_n), .flash_oe_n(f_oe_n), .flash_we_n(f_we_n), .flash_addr(f_addr),
      .byte_lines_in(bus_in), .byte_lines_out(h_out), .byte_lines_oe(h_oe),
      .ready_busy_n(rdy_n));
   frp_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) frp_flash_model_inst (.pclk(pclk),
      .reset_n(f_rst_n), .reset_hv(f_hv), .a9_hv(f_a9), .ce_n(f_ce_n), .oe_n(f_oe_n),
      .we_n(f_we_n), .addr(f_addr), .dout(m_out), .dout_oe(m_oe), .ready_busy_n(rdy_n));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task end_sim;
      $display("Compares %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (m_oe || h_oe) begin
         bus_last <= bus_in;
      end
      if (!f_we_n) begin
         wr_byte <= h_out;
      end
      if (cycles == 20000) begin
         mismatches++;
         end_sim;
      end
   end

   task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Start one flash operation and poll until the controller is idle
   task run_op(input logic [2:0] code, input logic [20:0] a);
      apb(1'b1, AD, {11'h000, a});
      apb(1'b1, CT, {27'h0000000, temp, code, 1'b1});
      do apb(1'b0, ST, 32'h00000000); while (rd[0] !== 1'b0);
      st = rd;
   endtask

   task wait_ready;
      do apb(1'b0, ST, 32'h00000000); while (rd[1] !== 1'b1);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      temp = 1'b0;
      bus_last = 8'h00;
      mismatches = 0;
      n_tests = 0;
      cycles = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, PM, 32'h00000000);
      check(rd, 32'h00000000, "protect map at reset");
      run_op(3'd3, 21'h05ff82);
      check(st[15:8], 8'h00, "fresh sector unprotected");
      run_op(3'd3, 21'h000000);
      check(st[15:8], MAKER, "maker code");
      run_op(3'd3, 21'h000001);
      check(st[15:8], PART, "part code");
      run_op(3'd0, 21'h1abcde);
      check(st[15:8], 8'hde ^ 8'h5a, "array read");
      apb(1'b0, 8'h14, 32'h00000000);
      check(err, 1'b1, "unmapped offset");
      apb(1'b1, PM, 32'h00000001);
      check(err, 1'b1, "protect map write");
      run_op(3'd5, 21'h000000);
      check(st[2], 1'b1, "unprotect with gaps refused");
      apb(1'b1, ST, 32'h00000004);
      apb(1'b0, ST, 32'h00000000);
      check(rd[2], 1'b0, "refused flag clear");
      run_op(3'd4, 21'h030002);
      apb(1'b0, PM, 32'h00000000);
      check(rd, 32'h00000008, "one sector flag");
      run_op(3'd3, 21'h03ff82);
      check(st[15:8], 8'h01, "top of sector 3 protected");
      run_op(3'd3, 21'h040002);
      check(st[15:8], 8'h00, "sector 4 unprotected");
      run_op(3'd1, 21'h030010);
      check(st[1], 1'b1, "protected write ignored");
      apb(1'b1, `FRP_OFS_WDATA, 32'h000000a5);
      run_op(3'd1, 21'h040010);
      check(st[1], 1'b0, "open write busy");
      check(wr_byte, 8'ha5, "write data on pins");
      wait_ready;
      temp = 1'b1;
      apb(1'b1, CT, 32'h00000010);
      apb(1'b0, ST, 32'h00000000);
      check(rd[4], 1'b1, "elevated reset level");
      run_op(3'd1, 21'h030010);
      check(st[1], 1'b0, "temporary unprotect write");
      wait_ready;
      temp = 1'b0;
      apb(1'b1, CT, 32'h00000000);
      run_op(3'd1, 21'h030010);
      check(st[1], 1'b1, "protection back");
      run_op(3'd3, 21'h03ff82);
      check(st[15:8], 8'h01, "flag kept");
      run_op(3'd1, 21'h040010);
      t0 = cycles;
      run_op(3'd2, 21'h000000);
      check(st[3], 1'b1, "restart advised");
      check(cycles - t0 > 60, 1'b1, "waited for busy reset");
      apb(1'b1, ST, 32'h00000008);
      run_op(3'd2, 21'h000000);
      check(st[3:1], 3'b001, "idle reset");
      run_op(3'd0, 21'h000123);
      check(st[15:8], 8'h23 ^ 8'h5a, "array read after reset");
      for (int i = 0; i < 32; i++) begin
         run_op(3'd4, {i[4:0], 16'h0002});
      end
      apb(1'b0, PM, 32'h00000000);
      check(rd, 32'hffffffff, "all protected");
      run_op(3'd5, 21'h000000);
      apb(1'b0, PM, 32'h00000000);
      check(rd, 32'h00000000, "all unprotected");
      run_op(3'd3, 21'h03ff82);
      check(st[15:8], 8'h00, "device flag cleared");
      end_sim;
   end
endmodule
`default_nettype wire
